// File: rtl/basic_timer_capture.v
// basic 16-bit up-counting timer with one input capture channel
`timescale 1ns/100ps
`include "timer_regs.vh"

// Behaviour
// R1: 16-bit up counter, reload, programmable prescaler
// R2: reload preload moves to shadow per buffer bit
// R3: overflow with update unblocked makes update event
// R4: counter enable follows run bit one cycle later
// R5: 16-bit prescaler divides by 1 to 65536
// R6: divider write waits for next update event
// R7: count 0 to reload, wrap, flag overflow
// R8: force update pulse makes update, reads zero
// R9: blocked update still restarts both counters
// R10: source select hides forced update from flag
// R11: update loads reload shadow and divider buffer
// R12: prescaler clocked once run bit is set
// R13: capture lands shadow then preload; compare reverse (code loads shadow and preload in the same cycle on capture)
// R14: input filtered, edge selected, events divided
// R15: capture latches count, sets flag, interrupt
// R16: capture on set flag sets overcapture
// R17: flag clears by write or read; overcapture by write
// R18: nonzero direction is input, value read-only
// R19: filter setting three needs eight samples
// R20: divide setting zero captures every edge
// R21: capture generate bit acts as an edge
// R22: software reads value before overcapture flag
// R23: buffer bit off means immediate reload writes
// R24: source select one: only overflow raises interrupt

module basic_timer_capture (
  // clock, reset, clock enable
  input wire clk,
  input wire reset_n,
  input wire clk_en,
  // control bits
  input wire count_run_bit,
  input wire update_block,
  input wire update_source_select,
  input wire reload_buffer_on,
  input wire [1:0] clock_div_sel,
  input wire update_irq_enable,
  // event generation strobes
  input wire force_update_bit,
  input wire capture_generate_bit,
  // counter access
  input wire count_wr,
  input wire [15:0] count_wdata,
  output wire [15:0] count_value_reg,
  // divider access
  input wire divider_wr,
  input wire [15:0] divider_wdata,
  output wire [15:0] divider_reg,
  // reload access
  input wire reload_wr,
  input wire [15:0] reload_wdata,
  output wire [15:0] reload_reg,
  // channel configuration
  input wire [1:0] channel_direction_sel,
  input wire [3:0] input_filter_sel,
  input wire [1:0] input_divide_sel,
  input wire capture_polarity,
  input wire capture_polarity_n,
  input wire capture_enable_ch1,
  input wire capture_irq_enable_ch1,
  // channel value access
  input wire channel_wr,
  input wire [15:0] channel_wdata,
  input wire channel_rd,
  output wire [15:0] channel_value_reg,
  // flag clears (software writes 0)
  input wire update_flag_clear,
  input wire capture_flag_clear,
  input wire overcapture_flag_clear,
  // external input
  input wire channel_input_pin,
  // status
  output wire counter_enabled,
  output wire update_flag,
  output wire capture_flag,
  output wire overcapture_flag,
  output wire filtered_input,
  output wire update_irq,
  output wire capture_irq
);

  // ************************************
  // state registers
  // ************************************
  reg [15:0] cnt_reg; // main counter
  reg [15:0] cnt_next;
  reg [15:0] psc_cnt_reg; // prescaler counter
  reg [15:0] psc_cnt_next;
  reg [15:0] psc_buf_reg; // active divide ratio
  reg [15:0] div_pre_reg; // software divide value
  reg [15:0] arr_pre_reg; // reload preload
  reg [15:0] arr_shadow_reg; // reload shadow
  reg [15:0] ccr_pre_reg; // channel preload
  reg [15:0] ccr_shadow_reg; // channel shadow
  reg cnt_en_reg; // delayed copy of run bit
  reg upd_flag_reg; // update flag
  reg ccif_reg;
  reg ccof_reg;
  reg uirq_reg;
  reg cirq_reg;

  // ************************************
  // combinational event wires
  // ************************************
  wire [15:0] active_reload;
  wire psc_done;
  wire count_tick;
  wire overflow;
  wire restart;
  wire update_event;
  wire update_flag_set;
  wire input_mode;
  wire divided_capture_trigger;
  wire pin_capture;
  wire capture_event;
  wire upd_flag_next;
  wire ccif_next;
  wire ccof_next;

  // ************************************
  // output wiring
  // ************************************
  assign count_value_reg = cnt_reg;
  assign divider_reg = div_pre_reg;
  assign reload_reg = arr_pre_reg;
  assign channel_value_reg = ccr_pre_reg;
  assign counter_enabled = cnt_en_reg;
  assign update_flag = upd_flag_reg;
  assign capture_flag = ccif_reg;
  assign overcapture_flag = ccof_reg;
  assign update_irq = uirq_reg;
  assign capture_irq = cirq_reg;

  // ************************************
  // time base
  // ************************************
  // unbuffered mode reads the preload directly so writes act at once
  assign active_reload = reload_buffer_on ? arr_shadow_reg : arr_pre_reg; // R23 R2
  // prescaler terminal count; ratio is buffer + 1
  assign psc_done = (psc_cnt_reg == psc_buf_reg); // R5
  // counter moves only on prescaler output while enabled
  assign count_tick = cnt_en_reg & count_run_bit & psc_done; // R4
  // a zero reload leaves the counter idle, so no overflow
  assign overflow = count_tick && (active_reload != 16'h0000) && (cnt_reg == active_reload); // R7
  // forced update restarts counters even while blocked
  assign restart = overflow | force_update_bit; // R9
  assign update_event = restart & ~update_block; // R3 R8
  // forced update hides from the flag when source select is set
  assign update_flag_set = update_event & (overflow | ~update_source_select); // R10 R24

  // counter and prescaler next values
  always @* begin
    cnt_next = cnt_reg;
    psc_cnt_next = psc_cnt_reg;
    if (restart) begin
      // both restart from zero, old ratio kept if blocked
      cnt_next = 16'h0000; // R9
      psc_cnt_next = 16'h0000;
    end else if (count_wr) begin
      cnt_next = count_wdata;
    end else begin
      if (count_run_bit) begin
        // prescaler receives clock as soon as run bit is high
        psc_cnt_next = psc_done ? 16'h0000 : psc_cnt_reg + 16'h0001; // R12
      end
      if (count_tick && active_reload != 16'h0000) begin
        cnt_next = cnt_reg + 16'h0001; // R1
      end
    end
  end

  // time base registers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= `CNT_RESET;
      psc_cnt_reg <= 16'h0000;
      psc_buf_reg <= `DIVIDER_RESET;
      div_pre_reg <= `DIVIDER_RESET;
      arr_pre_reg <= `RELOAD_RESET;
      arr_shadow_reg <= `RELOAD_RESET;
      cnt_en_reg <= 1'b0;
    end else if (clk_en) begin
      cnt_reg <= cnt_next;
      psc_cnt_reg <= psc_cnt_next;
      // enable lags the run bit by exactly one cycle
      cnt_en_reg <= count_run_bit; // R4
      if (divider_wr) begin
        div_pre_reg <= divider_wdata; // R6
      end
      if (reload_wr) begin
        arr_pre_reg <= reload_wdata; // R2
      end
      // shadows load on a real update event; the reload shadow also follows the preload while unbuffered
      if (update_event) begin
        psc_buf_reg <= div_pre_reg; // R11 R6
        arr_shadow_reg <= arr_pre_reg; // R11
      end else if (!reload_buffer_on) begin
        // keep shadow tracking so enabling the buffer is seamless
        arr_shadow_reg <= arr_pre_reg; // R2
      end
    end
  end

  // ************************************
  // channel input stage
  // ************************************
  // any nonzero direction makes the channel an input
  assign input_mode = (channel_direction_sel != `DIR_OUTPUT); // R18

  capture_input_stage u_input_stage (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .channel_input_pin(channel_input_pin),
    .input_filter_sel(input_filter_sel),
    .sample_div_sel(clock_div_sel),
    .edge_pol(capture_polarity),
    .edge_pol_n(capture_polarity_n),
    .input_divide_sel(input_divide_sel),
    .stage_enable(capture_enable_ch1),
    .filtered_input(filtered_input),
    .divided_capture_trigger(divided_capture_trigger)
  );

  // only the own-input mapping has a source in this block
  assign pin_capture = divided_capture_trigger & capture_enable_ch1
    & (channel_direction_sel == `DIR_OWN_INPUT); // R18
  // software generate behaves like an input edge
  assign capture_event = pin_capture | capture_generate_bit; // R21

  // ************************************
  // flags, set wins over clear
  // ************************************
  assign upd_flag_next = update_flag_set | (upd_flag_reg & ~update_flag_clear); // R3
  // read of captured value also clears the capture flag
  assign ccif_next = capture_event | (ccif_reg & ~capture_flag_clear & ~channel_rd); // R15 R17
  // overcapture clears only by a write of zero
  assign ccof_next = (capture_event & ccif_reg) | (ccof_reg & ~overcapture_flag_clear); // R16 R17

  // ************************************
  // channel value and flag registers
  // ************************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ccr_pre_reg <= `CHAN_RESET;
      ccr_shadow_reg <= `CHAN_RESET;
      upd_flag_reg <= 1'b0;
      ccif_reg <= 1'b0;
      ccof_reg <= 1'b0;
      uirq_reg <= 1'b0;
      cirq_reg <= 1'b0;
    end else if (clk_en) begin
      if (input_mode) begin
        // capture into shadow and preload together,
        // so a read right after the event already sees it
        if (capture_event) begin
          ccr_shadow_reg <= cnt_reg; // R13 R15
          ccr_pre_reg <= cnt_reg; // R13
        end
      end else begin
        // compare use: software writes preload, shadow follows
        if (channel_wr) begin
          ccr_pre_reg <= channel_wdata; // R18
        end
        ccr_shadow_reg <= ccr_pre_reg; // R13
      end
      upd_flag_reg <= upd_flag_next;
      ccif_reg <= ccif_next;
      ccof_reg <= ccof_next;
      // interrupt lines follow the flags gated by enables
      uirq_reg <= upd_flag_next & update_irq_enable;
      cirq_reg <= ccif_next & capture_irq_enable_ch1; // R15
    end
  end

endmodule

// File: rtl/capture_input_stage.v
// channel input stage: synchroniser, digital filter, edge select, event divider
`timescale 1ns/100ps
`include "timer_regs.vh"

module capture_input_stage (
  // clock and reset
  input wire clk,
  input wire reset_n,
  input wire clk_en,
  // external pin
  input wire channel_input_pin,
  // configuration
  input wire [3:0] input_filter_sel,
  input wire [1:0] sample_div_sel,
  input wire edge_pol,
  input wire edge_pol_n,
  input wire [1:0] input_divide_sel,
  input wire stage_enable,
  // results
  output reg filtered_input,
  output reg divided_capture_trigger
);

  // ************************************
  // decode helpers
  // ************************************
  // consecutive samples needed; unlisted settings use the longest
  function [3:0] filter_len;
    input [3:0] sel;
    begin
      case (sel)
        `FILT_OFF: filter_len = `FILT_LEN1;
        `FILT_LEN2_SEL: filter_len = `FILT_LEN2;
        `FILT_LEN4_SEL: filter_len = `FILT_LEN4;
        default: filter_len = `FILT_LEN8;
      endcase
    end
  endfunction

  // ************************************
  // registers
  // ************************************
  reg sync1_reg; // first stage, read only by sync2
  reg sync2_reg;
  reg sync3_reg;
  reg [1:0] dts_cnt_reg; // sample clock divider
  reg [3:0] filt_cnt_reg; // samples seen at new level
  reg prev_reg; // filtered level one cycle ago
  reg [2:0] ev_cnt_reg; // event divider
  wire stable; // second and third stages agree
  wire sample_tick;
  wire rise;
  wire fall;
  reg [1:0] dts_tc;
  reg [2:0] ev_mask;
  reg edge_hit;

  assign stable = (sync2_reg == sync3_reg);
  assign sample_tick = (dts_cnt_reg == dts_tc);
  assign rise = filtered_input & ~prev_reg;
  assign fall = ~filtered_input & prev_reg;

  // sample rate and divider masks
  always @* begin
    case (sample_div_sel)
      `DTS_DIV1: dts_tc = `DTS_TC1;
      `DTS_DIV2: dts_tc = `DTS_TC2;
      default: dts_tc = `DTS_TC4; // reserved code runs as divide by 4
    endcase
    case (input_divide_sel)
      `DIV_NONE: ev_mask = `EVMASK_1; // R20
      `DIV_BY2: ev_mask = `EVMASK_2;
      `DIV_BY4: ev_mask = `EVMASK_4;
      default: ev_mask = `EVMASK_8;
    endcase
    // polarity select; reserved pair behaves as rising
    if (edge_pol && edge_pol_n) begin
      edge_hit = rise | fall;
    end else if (edge_pol) begin
      edge_hit = fall;
    end else begin
      edge_hit = rise;
    end
  end

  // ************************************
  // synchroniser, filter, divider
  // ************************************
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      dts_cnt_reg <= 2'h0;
      filt_cnt_reg <= 4'h0;
      filtered_input <= 1'b0;
      prev_reg <= 1'b0;
      ev_cnt_reg <= 3'h0;
      divided_capture_trigger <= 1'b0;
    end else if (clk_en) begin
      sync1_reg <= channel_input_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      dts_cnt_reg <= sample_tick ? 2'h0 : dts_cnt_reg + 2'h1;
      prev_reg <= filtered_input;
      // a level must hold for the full count of samples
      if (!stable || sync3_reg == filtered_input) begin
        filt_cnt_reg <= 4'h0;
      end else if (sample_tick) begin
        if (filt_cnt_reg + 4'h1 >= filter_len(input_filter_sel)) begin // R19
          filtered_input <= sync3_reg;
          filt_cnt_reg <= 4'h0;
        end else begin
          filt_cnt_reg <= filt_cnt_reg + 4'h1;
        end
      end
      // divider is held cleared while capture is off
      divided_capture_trigger <= 1'b0;
      if (!stage_enable) begin
        ev_cnt_reg <= 3'h0;
      end else if (edge_hit) begin // R14
        if ((ev_cnt_reg & ev_mask) == ev_mask) begin
          ev_cnt_reg <= 3'h0;
          divided_capture_trigger <= 1'b1;
        end else begin
          ev_cnt_reg <= ev_cnt_reg + 3'h1;
        end
      end
    end
  end

endmodule

// File: rtl/timer_regs.vh
// constants of the basic timer with one capture channel
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

// ************************************
// widths
// ************************************
`define CNT_WIDTH 16
`define FILT_SEL_WIDTH 4

// ************************************
// reset values
// ************************************
`define CNT_RESET 16'h0000
`define RELOAD_RESET 16'h0000
`define DIVIDER_RESET 16'h0000
`define CHAN_RESET 16'h0000

// ************************************
// channel direction field encodings
// ************************************
`define DIR_OUTPUT 2'h0
`define DIR_OWN_INPUT 2'h1

// ************************************
// input filter settings and lengths
// ************************************
`define FILT_OFF 4'h0
`define FILT_LEN2_SEL 4'h1
`define FILT_LEN4_SEL 4'h2
`define FILT_LEN8_SEL 4'h3
`define FILT_LEN1 4'h1
`define FILT_LEN2 4'h2
`define FILT_LEN4 4'h4
`define FILT_LEN8 4'h8

// ************************************
// filter sample clock division (terminal counts)
// ************************************
`define DTS_DIV1 2'h0
`define DTS_DIV2 2'h1
`define DTS_TC1 2'h0
`define DTS_TC2 2'h1
`define DTS_TC4 2'h3

// ************************************
// input event division
// ************************************
`define DIV_NONE 2'h0
`define DIV_BY2 2'h1
`define DIV_BY4 2'h2
`define EVMASK_1 3'h0
`define EVMASK_2 3'h1
`define EVMASK_4 3'h3
`define EVMASK_8 3'h7

`endif

// File: tb/pin_source.sv
// model of the signal source driving the channel input pin
`timescale 1ns/100ps
module pin_source (
  // bench clock
  input wire clk,
  // pulse request and high length in clocks
  input wire go,
  input wire [7:0] high_len,
  // pin toward the timer
  output reg channel_input_pin
);
  // high cycles still to send
  reg [7:0] left_reg;
  initial begin
    channel_input_pin = 1'b0;
    left_reg = 8'h00;
  end
  // pin moves just after the edge, like the bench, so it never races sampling
  always @(posedge clk) begin
    if (go) begin
      left_reg <= high_len;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end
    channel_input_pin <= #5 (go || left_reg > 8'h01);
  end
endmodule

// File: tb/tb_top.sv
// self-checking bench for the basic timer with one capture channel
`timescale 1ns/100ps
module tb_top;
  // ************************************
  // signals
  // ************************************
  localparam int FUP = 0, GEN = 1, CWR = 2, DWR = 3, RWR = 4, HWR = 5, HRD = 6, UCL = 7, CCL = 8, OCL = 9, GO = 10;
  logic clk, reset_n, clk_en, run, ublk, usrc, rbuf, uie, cap_en, cie, pol, pol_n;
  logic [10:0] stb; // one-cycle strobes, indexed above
  logic [15:0] cwd, dwd, rwd, chwd, prev;
  logic [1:0] dir, dsel, cdiv;
  logic [3:0] fsel;
  logic [7:0] plen;
  wire [15:0] cnt, dreg, rreg, chv;
  wire pin, cena, uf, cf, of, fin, uirq, cirq;
  int mismatches, n_checks, c;
  basic_timer_capture i_dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .count_run_bit(run),
    .update_block(ublk), .update_source_select(usrc), .reload_buffer_on(rbuf), .clock_div_sel(cdiv),
    .update_irq_enable(uie), .force_update_bit(stb[FUP]), .capture_generate_bit(stb[GEN]), .count_wr(stb[CWR]),
    .count_wdata(cwd), .count_value_reg(cnt), .divider_wr(stb[DWR]), .divider_wdata(dwd), .divider_reg(dreg),
    .reload_wr(stb[RWR]), .reload_wdata(rwd), .reload_reg(rreg), .channel_direction_sel(dir),
    .input_filter_sel(fsel), .input_divide_sel(dsel), .capture_polarity(pol), .capture_polarity_n(pol_n),
    .capture_enable_ch1(cap_en), .capture_irq_enable_ch1(cie), .channel_wr(stb[HWR]), .channel_wdata(chwd),
    .channel_rd(stb[HRD]), .channel_value_reg(chv), .update_flag_clear(stb[UCL]), .capture_flag_clear(stb[CCL]),
    .overcapture_flag_clear(stb[OCL]), .channel_input_pin(pin), .counter_enabled(cena), .update_flag(uf),
    .capture_flag(cf), .overcapture_flag(of), .filtered_input(fin), .update_irq(uirq), .capture_irq(cirq));
  pin_source i_src (.clk(clk), .go(stb[GO]), .high_len(plen), .channel_input_pin(pin));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ************************************
  // tasks
  // ************************************
  task tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one-cycle strobe, then a quiet cycle so strobes never abut
  task pulse(input int b);
    stb[b] = 1'b1;
    tick(1);
    stb[b] = 1'b0;
    tick(1);
  endtask
  // counter changes seen over n cycles
  task steps(input int n);
    c = 0;
    repeat (n) begin
      prev = cnt;
      tick(1);
      if (cnt !== prev) c++;
    end
  endtask
  // counter steps by one and wraps to zero after top
  task wrapchk(input logic [15:0] top);
    repeat (8) begin
      prev = cnt;
      tick(1);
      chk(cnt, (prev == top) ? 16'h0000 : prev + 16'h0001);
    end
  endtask
  // bounded wait for the capture flag
  task waitcap(input int lim, input logic exp);
    c = 0;
    while (cf !== 1'b1 && c < lim) begin
      tick(1);
      c++;
    end
    chk(cf, exp);
    if (exp && c == lim) give_verdict;
  endtask
  // ************************************
  // sequence
  // ************************************
  initial begin
    {reset_n, run, ublk, usrc, rbuf, uie, cap_en, cie, pol, pol_n, stb} = '0;
    {cwd, dwd, rwd, chwd, dir, dsel, cdiv, fsel, plen} = '0;
    clk_en = 1'b1;
    mismatches = 0;
    n_checks = 0;
    tick(20);
    reset_n = 1'b1;
    tick(1);
    chk(cnt, 16'h0000);
    chk(cena, 1'b0);
    rwd = 16'h0003;
    pulse(RWR);
    chk(rreg, 16'h0003);
    run = 1'b1;
    uie = 1'b1;
    tick(1);
    chk(cena, 1'b1);
    tick(3);
    wrapchk(16'h0003);
    chk(uf, 1'b1);
    chk(uirq, 1'b1);
    rwd = 16'h0100;
    pulse(RWR);
    cwd = 16'h0010;
    pulse(CWR);
    chk(cnt, 16'h0011);
    dwd = 16'h0001;
    pulse(DWR);
    chk(dreg, 16'h0001);
    steps(4);
    chk(c, 4);
    pulse(FUP);
    steps(8);
    chk(c, 4);
    ublk = 1'b1;
    dwd = 16'h0000;
    pulse(DWR);
    pulse(UCL);
    pulse(FUP);
    chk(uf, 1'b0);
    steps(8);
    chk(c, 4);
    ublk = 1'b0;
    usrc = 1'b1;
    pulse(FUP);
    chk(uf, 1'b0);
    steps(4);
    chk(c, 4);
    usrc = 1'b0;
    pulse(FUP);
    chk(uf, 1'b1);
    rbuf = 1'b1;
    rwd = 16'h0003;
    pulse(RWR);
    steps(6);
    chk(cnt > 16'h0003, 1'b1);
    pulse(FUP);
    wrapchk(16'h0003);
    clk_en = 1'b0;
    steps(3);
    chk(c, 0);
    clk_en = 1'b1;
    run = 1'b0;
    tick(2);
    pulse(FUP);
    chk(cnt, 16'h0000);
    cwd = 16'h0ABC;
    pulse(CWR);
    {cie, cap_en, dir} = 4'hF;
    dir = 2'h1;
    pulse(GEN);
    chk(cf, 1'b1);
    chk(chv, 16'h0ABC);
    chk(cirq, 1'b1);
    chwd = 16'h55AA;
    pulse(HWR);
    chk(chv, 16'h0ABC);
    pulse(GEN);
    chk(of, 1'b1);
    cap_en = 1'b0;
    pulse(HRD);
    chk(cf, 1'b0);
    chk(of, 1'b1);
    pulse(OCL);
    chk(of, 1'b0);
    cap_en = 1'b1;
    run = 1'b1;
    plen = 8'h03;
    pulse(GO);
    waitcap(20, 1'b1);
    pulse(CCL);
    chk(cf, 1'b0);
    fsel = 4'h3;
    plen = 8'h05;
    pulse(GO);
    waitcap(30, 1'b0);
    plen = 8'h0E;
    pulse(GO);
    waitcap(40, 1'b1);
    chk(fin, 1'b1);
    pulse(CCL);
    fsel = 4'h0;
    plen = 8'h03;
    pulse(GO);
    tick(8);
    pulse(GO);
    tick(12);
    chk(of, 1'b1);
    pulse(CCL);
    dir = 2'h0;
    pulse(GO);
    waitcap(20, 1'b0);
    // both edges of one pulse make two events, divided by two into one capture
    dir = 2'h1;
    {pol, pol_n, dsel} = 4'hD;
    pulse(GO);
    tick(5);
    chk(cf, 1'b0);
    waitcap(20, 1'b1);
    // unbuffered zero reload acts at once and stops the counter
    rbuf = 1'b0;
    rwd = 16'h0000;
    pulse(RWR);
    steps(4);
    chk(c, 0);
    give_verdict;
  end
endmodule

// File: tb/timer_chk.sv
// assertion checker for the basic timer with one capture channel
`timescale 1ns/100ps
module timer_chk (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // controls
  input wire clk_en,
  input wire count_run_bit,
  input wire update_block,
  input wire update_source_select,
  input wire reload_buffer_on,
  input wire force_update_bit,
  input wire capture_generate_bit,
  input wire count_wr,
  input wire reload_wr,
  input wire [1:0] channel_direction_sel,
  input wire capture_enable_ch1,
  input wire channel_rd,
  input wire overcapture_flag_clear,
  // observed state
  input wire [15:0] count_value_reg,
  input wire [15:0] reload_reg,
  input wire [15:0] channel_value_reg,
  input wire counter_enabled,
  input wire update_flag,
  input wire capture_flag,
  input wire overcapture_flag
);
  // ************************************
  // checks
  // ************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // software capture that an input channel must take
  wire cap_req;
  assign cap_req = capture_generate_bit && capture_enable_ch1 && (channel_direction_sel != 2'h0);
  a_run_to_enable: assert property (clk_en |=> counter_enabled == $past(count_run_bit))
    else $error("counter enable not one cycle behind run bit");
  a_force_restart: assert property (clk_en && force_update_bit |=> count_value_reg == 16'h0000)
    else $error("forced update did not restart the counter");
  a_flag_has_cause: assert property ($rose(update_flag) |-> count_value_reg == 16'h0000 && !$past(update_block))
    else $error("update flag rose without a restart");
  a_forced_flag_hidden: assert property (clk_en && force_update_bit && update_source_select && !reload_buffer_on
    && count_value_reg != reload_reg && !update_flag |=> !update_flag)
    else $error("hidden forced update set the flag");
  a_capture_latch: assert property (clk_en && cap_req |=> capture_flag
    && channel_value_reg == $past(count_value_reg))
    else $error("capture did not latch count and flag");
  a_overcapture_set: assert property (clk_en && cap_req && capture_flag |=> overcapture_flag)
    else $error("second capture missed overcapture");
  a_read_clears: assert property (clk_en && channel_rd && !capture_enable_ch1 && !capture_generate_bit
    |=> !capture_flag)
    else $error("read did not clear capture flag");
  a_overcapture_keeps: assert property (clk_en && overcapture_flag && !overcapture_flag_clear
    |=> overcapture_flag)
    else $error("overcapture cleared without write");
  a_zero_reload_holds: assert property (clk_en && reload_reg == 16'h0000 && !reload_buffer_on && !reload_wr
    && !count_wr && !force_update_bit |=> $stable(count_value_reg))
    else $error("counter moved with zero reload");
  c_forced: cover property (clk_en && force_update_bit);
  c_update: cover property ($rose(update_flag));
  c_overcapture: cover property ($rose(overcapture_flag));
endmodule

bind basic_timer_capture timer_chk i_chk (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
  .count_run_bit(count_run_bit), .update_block(update_block), .update_source_select(update_source_select),
  .reload_buffer_on(reload_buffer_on), .force_update_bit(force_update_bit),
  .capture_generate_bit(capture_generate_bit), .count_wr(count_wr), .reload_wr(reload_wr),
  .channel_direction_sel(channel_direction_sel), .capture_enable_ch1(capture_enable_ch1),
  .channel_rd(channel_rd), .overcapture_flag_clear(overcapture_flag_clear), .count_value_reg(count_value_reg),
  .reload_reg(reload_reg), .channel_value_reg(channel_value_reg), .counter_enabled(counter_enabled),
  .update_flag(update_flag), .capture_flag(capture_flag), .overcapture_flag(overcapture_flag));
